// ---- rtl/rpc_pkg.sv ----
// constants, types and register map of the remote pump control block
// Contract
// - A remote input counts as asserted when its line is pulled to ground, idle when left open.
// - The motor starts on a run request only with the stop line closed and no inhibit present.
// - An open stop line stops the motor and run requests are ignored until it closes again.
// - The local/remote select line enables all remote inputs and outputs and gates run requests.
// - Direction changes only with select and stop closed and the pump stopped.
// - An open rotation input means clockwise, a closed one counter-clockwise.
// - An asserted outlet-full input raises its display flag and the combined alarm.
// - An asserted inlet-empty input raises its display flag and the combined alarm.
// - A spill report raises its display flag and the combined alarm.
// - The speed pulse output is a clock from zero to 1024 Hz scaled to pump speed.
// - In follower mode speed follows the follower pulse frequency of zero to 1024 Hz.
// - In follower mode speed is a set percentage of the leader speed measured from that input.
// - In maintained mode the pump runs only while run is held and stops on release or stop.
// - In non-maintained mode a run pulse is latched until a separate stop condition occurs.
package rpc_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DEB_MS = 5;
  localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  localparam int unsigned FILT_US = 20;
  localparam int unsigned FILT_CYC = CLK_HZ / 1_000_000 * FILT_US;
  localparam int unsigned GATE_MS = 1000;
  localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned FULL_HZ = 1024;
  // two toggles per output period
  localparam int unsigned TGL_CYC = CLK_HZ / (2 * FULL_HZ);
  localparam logic [8:0] MAX_RPM = 9'h190;
  localparam logic [7:0] PCT_FULL = 8'h64;
  // ****************************************************************
  // contact inputs, index into the packed pin vector
  // ****************************************************************
  localparam int NUM_IN = 8;
  localparam int IX_FOLLOW = 0;
  localparam int IX_SPILL = 1;
  localparam int IX_EMPTY = 2;
  localparam int IX_FULL = 3;
  localparam int IX_DIR = 4;
  localparam int IX_SEL = 5;
  localparam int IX_STOP = 6;
  localparam int IX_START = 7;
  typedef struct packed {
    logic start;
    logic stop;
    logic sel;
    logic dir;
    logic full;
    logic empty;
    logic spill;
    logic follow;
  } rpc_pins_t;
  typedef struct packed {
    logic full;
    logic empty;
    logic spill;
  } rpc_alarm_t;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SPEED = 8'h04;
  localparam logic [7:0] OFS_PCT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RPM = 8'h10;
  localparam logic [7:0] OFS_FREQ = 8'h14;
  localparam int CTRL_MAINT = 0;
  localparam int CTRL_FOLLOW = 1;
  localparam int CTRL_INHIBIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [8:0] SPEED_RST = 9'h000;
endpackage : rpc_pkg

// ---- rtl/rpc_debounce.sv ----
// two-flop synchroniser and hold-time debounce for one active-low contact
module rpc_debounce #(
  parameter int unsigned CYC = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_n,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= pin_n;
      s2_r <= s1_r;
    end
  end

  // grounded line is asserted; level moves only after a full quiet hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
      cnt_r <= 32'h0;
    end else if (~s2_r == level) begin
      cnt_r <= 32'h0;
    end else if (cnt_r == CYC - 1) begin
      level <= ~s2_r;
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_deb_hold: assert property ($changed(level) |-> $past(cnt_r) == CYC - 1)
    else $error("debounced level changed before hold time");
endmodule : rpc_debounce

// ---- rtl/rpc_freq_meter.sv ----
// counts rising edges of the follower pulse over a fixed gate window
module rpc_freq_meter #(
  parameter int unsigned GATE = 1000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pulse,
  output logic [15:0] freq_hz
);
  logic prev_r;
  logic [15:0] edges_r;
  logic [31:0] gate_r;
  logic rise;
  logic gate_end;

  assign rise = pulse & ~prev_r;
  assign gate_end = (gate_r == GATE - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
      gate_r <= 32'h0;
    end else begin
      prev_r <= pulse;
      gate_r <= gate_end ? 32'h0 : gate_r + 32'h1;
    end
  end

  // saturates rather than wraps on an out-of-range input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edges_r <= 16'h0;
      freq_hz <= 16'h0;
    end else if (gate_end) begin
      freq_hz <= edges_r;
      edges_r <= {15'h0, rise};
    end else if (rise && edges_r != 16'hFFFF) begin
      edges_r <= edges_r + 16'h1;
    end
  end
endmodule : rpc_freq_meter

// ---- rtl/rpc_top.sv ----
// remote I/O pump control: contacts, run logic, alarms, speed pulses, AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
module rpc_top
  import rpc_pkg::*;
#(
  parameter int unsigned DEB_CYC_P = rpc_pkg::DEB_CYC,
  parameter int unsigned FILT_CYC_P = rpc_pkg::FILT_CYC,
  parameter int unsigned GATE_CYC_P = rpc_pkg::GATE_CYC,
  parameter int unsigned TGL_CYC_P = rpc_pkg::TGL_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire rpc_pkg::rpc_pins_t PINS_N,
  output logic RUN,
  output logic DIR_CCW,
  output rpc_pkg::rpc_alarm_t ALARM,
  output logic GEN_ALARM,
  output logic SPEED_PULSE,
  output logic [8:0] MOTOR_RPM,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  import rpc_pkg::*;

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  logic [NUM_IN-1:0] pin_vec;
  logic [NUM_IN-1:0] db;
  assign pin_vec = PINS_N;

  // follower pulse gets a short filter, contacts a long one
  generate
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      rpc_debounce #(
        .CYC((i == IX_FOLLOW) ? FILT_CYC_P : DEB_CYC_P)
      ) u_deb (
        .clk(CLK),
        .rst_b(RST_B),
        .pin_n(pin_vec[i]),
        .level(db[i])
      );
    end
  endgenerate

  logic remote_en;
  logic stop_cl;
  assign remote_en = db[IX_SEL];
  assign stop_cl = db[IX_STOP];

  // ****************************************************************
  // registers and bus state
  // ****************************************************************
  logic [2:0] ctrl_r;
  logic [8:0] speed_r;
  logic [7:0] pct_r;
  logic [15:0] freq_hz;
  logic run_r;
  logic dir_r;
  logic start_d_r;
  rpc_alarm_t alarm_r;
  logic gen_alarm_r;
  logic [8:0] rpm_r;
  logic pulse_r;

  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] rdata_r;
  logic ready_r;
  logic accept;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // size is not decoded: every register is one whole word
  assign accept = HSEL & HTRANS[1] & HREADY;

  // reads take one wait state so a write just before is seen
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      ready_r <= 1'b1;
    end else begin
      wr_pend_r <= accept & HWRITE;
      rd_pend_r <= accept & ~HWRITE;
      if (accept) begin
        addr_r <= HADDR[7:0];
      end
      ready_r <= ~(accept & ~HWRITE);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= CTRL_RST;
      speed_r <= SPEED_RST;
      pct_r <= PCT_FULL;
    end else if (wr_pend_r) begin
      if (hit(addr_r, OFS_CTRL)) begin
        ctrl_r <= HWDATA[2:0];
      end
      if (hit(addr_r, OFS_SPEED)) begin
        speed_r <= HWDATA[8:0];
      end
      if (hit(addr_r, OFS_PCT)) begin
        pct_r <= HWDATA[7:0];
      end
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r <= 32'h0;
    end else if (rd_pend_r) begin
      rdata_r <= 32'h0;
      if (hit(addr_r, OFS_CTRL)) begin
        rdata_r <= {29'h0, ctrl_r};
      end
      if (hit(addr_r, OFS_SPEED)) begin
        rdata_r <= {23'h0, speed_r};
      end
      if (hit(addr_r, OFS_PCT)) begin
        rdata_r <= {24'h0, pct_r};
      end
      if (hit(addr_r, OFS_STATUS)) begin
        rdata_r <= {24'h0, db[IX_START], stop_cl, alarm_r, remote_en, dir_r, run_r};
      end
      if (hit(addr_r, OFS_RPM)) begin
        rdata_r <= {23'h0, rpm_r};
      end
      if (hit(addr_r, OFS_FREQ)) begin
        rdata_r <= {16'h0, freq_hz};
      end
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = ready_r;
  assign HRESP = 1'b0;

  // ****************************************************************
  // run / stop
  // ****************************************************************
  logic run_ok;
  logic maint;
  logic start_rise;
  assign maint = ctrl_r[CTRL_MAINT];
  assign run_ok = remote_en & stop_cl & ~ctrl_r[CTRL_INHIBIT];
  assign start_rise = db[IX_START] & ~start_d_r;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      start_d_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      start_d_r <= db[IX_START];
      if (!run_ok) begin
        run_r <= 1'b0;
      end else if (maint) begin
        run_r <= db[IX_START];
      end else if (start_rise) begin
        run_r <= 1'b1;
      end
    end
  end

  // direction is frozen while running or not in remote control
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_r <= 1'b0;
    end else if (remote_en && stop_cl && !run_r) begin
      dir_r <= db[IX_DIR];
    end
  end

  // ****************************************************************
  // alarms
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      alarm_r <= '0;
      gen_alarm_r <= 1'b0;
    end else begin
      alarm_r.full <= remote_en & db[IX_FULL];
      alarm_r.empty <= remote_en & db[IX_EMPTY];
      alarm_r.spill <= remote_en & db[IX_SPILL];
      gen_alarm_r <= remote_en & (db[IX_FULL] | db[IX_EMPTY] | db[IX_SPILL]);
    end
  end

  // ****************************************************************
  // speed
  // ****************************************************************
  rpc_freq_meter #(
    .GATE(GATE_CYC_P)
  ) u_meter (
    .clk(CLK),
    .rst_b(RST_B),
    .pulse(db[IX_FOLLOW]),
    .freq_hz(freq_hz)
  );

  logic [31:0] lead_rpm;
  logic [31:0] follow_rpm;
  logic [8:0] target;

  // integer rpm; fractional rpm is dropped at each step
  always_comb begin
    lead_rpm = ({16'h0, freq_hz} * {23'h0, MAX_RPM}) / FULL_HZ;
    follow_rpm = (lead_rpm * {24'h0, pct_r}) / {24'h0, PCT_FULL};
    if (!ctrl_r[CTRL_FOLLOW]) begin
      target = (speed_r > MAX_RPM) ? MAX_RPM : speed_r;
    end else if (follow_rpm > {23'h0, MAX_RPM}) begin
      target = MAX_RPM;
    end else begin
      target = follow_rpm[8:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rpm_r <= 9'h000;
    end else begin
      rpm_r <= run_r ? target : 9'h000;
    end
  end

  // ****************************************************************
  // speed pulse: accumulate rpm each tick, toggle per MAX_RPM
  // ****************************************************************
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [9:0] acc_r;
  logic [9:0] acc_sum;
  assign tick = (tick_cnt_r == TGL_CYC_P - 1);
  assign acc_sum = acc_r + {1'b0, rpm_r};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_r <= 10'h000;
      pulse_r <= 1'b0;
    end else if (!remote_en || rpm_r == 9'h000) begin
      acc_r <= 10'h000;
      pulse_r <= 1'b0;
    end else if (tick) begin
      if (acc_sum >= {1'b0, MAX_RPM}) begin
        acc_r <= acc_sum - {1'b0, MAX_RPM};
        pulse_r <= ~pulse_r;
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  assign RUN = run_r;
  assign DIR_CCW = dir_r;
  assign ALARM = alarm_r;
  assign GEN_ALARM = gen_alarm_r;
  assign SPEED_PULSE = pulse_r;
  assign MOTOR_RPM = rpm_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  chk_run_needs_ok: assert property ($rose(run_r) |-> $past(stop_cl && remote_en))
    else $error("run started without stop closed and remote select");
  chk_stop_open: assert property (!stop_cl |=> !run_r)
    else $error("stop open but still running");
  chk_remote_off: assert property (!remote_en |=> !run_r && !gen_alarm_r ##1 !pulse_r)
    else $error("remote disabled but outputs active");
  chk_dir_stopped: assert property ($changed(dir_r) |-> $past(!run_r && stop_cl))
    else $error("direction changed while running");
  chk_dir_follow: assert property ($past(remote_en && stop_cl && !run_r) |-> dir_r == $past(db[IX_DIR]))
    else $error("direction not following rotation input");
  chk_alarm_full: assert property (remote_en && db[IX_FULL] |=> alarm_r.full && gen_alarm_r)
    else $error("outlet full alarm missing");
  chk_alarm_empty: assert property (remote_en && db[IX_EMPTY] |=> alarm_r.empty && gen_alarm_r)
    else $error("inlet empty alarm missing");
  chk_alarm_spill: assert property (remote_en && db[IX_SPILL] |=> alarm_r.spill && gen_alarm_r)
    else $error("spill alarm missing");
  chk_maint_release: assert property (maint && !db[IX_START] |=> !run_r)
    else $error("maintained mode kept running after release");
  chk_latch_hold: assert property (!maint && run_r && run_ok |=> run_r)
    else $error("non-maintained run dropped without stop");
  chk_pulse_idle: assert property (rpm_r == 9'h000 ##1 rpm_r == 9'h000 |-> !pulse_r)
    else $error("speed pulse active at zero speed");

  // ****************************************************************
  // latch, maintained-run, inhibit, direction, alarm and speed checks
  // ****************************************************************
  chk_inhibit_run: assert property (ctrl_r[CTRL_INHIBIT] |=> !run_r)
    else $error("run while inhibit set");
  chk_no_spurious_run: assert property (!maint && !run_r && !start_rise |=> !run_r)
    else $error("non-maintained run started without a start edge");
  chk_maint_run: assert property (maint && run_ok && db[IX_START] |=> run_r)
    else $error("maintained start held but not running");
  chk_latch_start: assert property ($rose(run_r) && $past(!maint) |-> $past(start_rise))
    else $error("latched run without a start edge");
  chk_dir_local: assert property (!remote_en |=> $stable(dir_r))
    else $error("direction changed while select open");
  chk_dir_stop_open: assert property (!stop_cl |=> $stable(dir_r))
    else $error("direction changed while stop open");
  chk_alarm_local: assert property (!remote_en |=> alarm_r == 3'h0)
    else $error("alarm flags raised while select open");
  chk_gen_alarm_any: assert property (gen_alarm_r == |alarm_r)
    else $error("combined alarm differs from alarm flags");
  chk_rpm_stopped: assert property (!run_r |=> rpm_r == 9'h000)
    else $error("speed held while stopped");
  chk_rpm_clamp: assert property (rpm_r <= MAX_RPM)
    else $error("speed above maximum");
  chk_pulse_tick: assert property (remote_en && rpm_r != 9'h000 && !tick
    |=> $stable(pulse_r))
    else $error("speed pulse moved between ticks");
  chk_follow_idle: assert property (ctrl_r[CTRL_FOLLOW] && freq_hz == 16'h0
    |=> rpm_r == 9'h000)
    else $error("follower speed without follower pulses");

  cov_run_start: cover property ($rose(run_r));
  cov_dir_change: cover property ($changed(dir_r));
  cov_gen_alarm: cover property ($rose(gen_alarm_r));
  cov_pulse: cover property ($rose(pulse_r));
  cov_follow_run: cover property (ctrl_r[CTRL_FOLLOW] && run_r && rpm_r != 9'h000);
endmodule : rpc_top

// ---- bench/rpc_plant_model.sv ----
// plant controller contacts and a leading pump's pulse train
module rpc_plant_model
  import rpc_pkg::*;
(
  input wire logic clk,
  output rpc_pkg::rpc_pins_t pins_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:1] lines_n = 7'h7F;
  logic follow_q = 1'b1;
  int half_per = 0;
  int cnt = 0;
  // open contact floats high through the pull-up, a closed one grounds the line
  assign pins_n = {lines_n, follow_q};
  task automatic set_line(input int ix, input logic closed);
    @(posedge clk);
    lines_n[ix] <= ~closed;
  endtask : set_line
  // chatter of one-cycle closures, far shorter than any debounce hold
  task automatic bounce(input int ix, input int n);
    repeat (n) begin
      @(posedge clk);
      lines_n[ix] <= ~lines_n[ix];
    end
    @(posedge clk);
    lines_n[ix] <= 1'b1;
  endtask : bounce
  task automatic set_follow(input int h);
    @(posedge clk);
    half_per <= h;
  endtask : set_follow
  // leading pump output, period of two half_per cycles, idle high when off
  always @(posedge clk) begin
    if (half_per == 0) begin
      follow_q <= 1'b1;
      cnt <= 0;
    end else if (cnt >= half_per - 1) begin
      follow_q <= ~follow_q;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : rpc_plant_model

// ---- bench/tb_top.sv ----
// self-checking bench for the remote pump control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rpc_pkg::*;
  localparam int DEB = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  rpc_pins_t pins_n;
  rpc_alarm_t alarm;
  logic run, dir_ccw, gen_alarm, spd_pulse, hreadyout, hresp;
  logic [8:0] motor_rpm;
  logic [31:0] hrdata;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  int n_errors = 0;
  int checked = 0;
  always #2 clk = ~clk;
  rpc_top #(.DEB_CYC_P(DEB), .FILT_CYC_P(2), .GATE_CYC_P(200), .TGL_CYC_P(4)) rpc_top_inst (
    .CLK(clk), .RST_B(rst_b), .PINS_N(pins_n), .RUN(run), .DIR_CCW(dir_ccw),
    .ALARM(alarm), .GEN_ALARM(gen_alarm), .SPEED_PULSE(spd_pulse), .MOTOR_RPM(motor_rpm),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp)
  );
  rpc_plant_model rpc_plant_model_inst (.clk(clk), .pins_n(pins_n));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      n_errors++;
    end
  endtask : check
  task automatic in_rng(input int n, input int lo, input int hi, input string what);
    check({31'h0, n >= lo && n <= hi}, 32'h1, what);
  endtask : in_rng
  // no fixed latency assumed: wait for hreadyout, bounded
  task automatic wait_rdy;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) begin
        return;
      end
    end
    $display("[ERR] %0t bus hang", $time);
    n_errors++;
    stop_test();
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, ofs, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, ofs, 32'h0, x);
    check(x, exp, "register read");
  endtask : rd_chk
  task automatic pin(input int ix, input logic closed);
    rpc_plant_model_inst.set_line(ix, closed);
  endtask : pin
  // contact path: sync, hold, one register stage, with margin
  task automatic settle;
    repeat (DEB + 8) @(posedge clk);
  endtask : settle
  task automatic count_tgl(input int cyc, output int n);
    logic prev;
    n = 0;
    prev = spd_pulse;
    repeat (cyc) begin
      @(posedge clk);
      if (spd_pulse !== prev) begin
        n++;
      end
      prev = spd_pulse;
    end
  endtask : count_tgl
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    check({25'h0, run, dir_ccw, alarm, gen_alarm, spd_pulse}, 32'h0, "reset outputs");
    check({21'h0, hreadyout, hresp, motor_rpm}, 32'h400, "bus and speed at reset");
    rd_chk(OFS_CTRL, {29'h0, CTRL_RST});
    rd_chk(OFS_PCT, {24'h0, PCT_FULL});
    rd_chk(8'h18, 32'h0);
    wr(OFS_SPEED, 32'h1FF);
    rd_chk(OFS_SPEED, 32'h1FF);
    wr(OFS_RPM, 32'h55);
    rd_chk(OFS_RPM, 32'h0);
    pin(IX_SEL, 1'b1);
    pin(IX_STOP, 1'b1);
  endtask : t_regs
  task automatic t_maint;
    wr(OFS_SPEED, 32'hC8);
    pin(IX_START, 1'b1);
    settle();
    check({31'h0, run}, 32'h1, "maintained run");
    check({23'h0, motor_rpm}, 32'hC8, "set speed");
    rd_chk(OFS_STATUS, 32'hC5);
    pin(IX_START, 1'b0);
    settle();
    check({31'h0, run}, 32'h0, "run released");
    rpc_plant_model_inst.bounce(IX_START, 6);
    settle();
    check({31'h0, run}, 32'h0, "bounce passed");
    wr(OFS_CTRL, 32'h5);
    pin(IX_START, 1'b1);
    settle();
    check({31'h0, run}, 32'h0, "inhibited run");
    wr(OFS_CTRL, 32'h1);
    settle();
    check({31'h0, run}, 32'h1, "inhibit cleared");
    pin(IX_STOP, 1'b0);
    settle();
    check({31'h0, run}, 32'h0, "stop opened");
    pin(IX_START, 1'b0);
    pin(IX_STOP, 1'b1);
  endtask : t_maint
  task automatic start_pulse;
    pin(IX_START, 1'b1);
    repeat (DEB + 6) @(posedge clk);
    pin(IX_START, 1'b0);
    settle();
  endtask : start_pulse
  task automatic t_latch;
    wr(OFS_CTRL, 32'h0);
    start_pulse();
    check({31'h0, run}, 32'h1, "latched run");
    pin(IX_STOP, 1'b0);
    settle();
    check({31'h0, run}, 32'h0, "stop clears latch");
    start_pulse();
    pin(IX_STOP, 1'b1);
    settle();
    check({31'h0, run}, 32'h0, "start during stop");
    start_pulse();
    pin(IX_SEL, 1'b0);
    settle();
    check({31'h0, run}, 32'h0, "select opened");
    start_pulse();
    check({31'h0, run}, 32'h0, "start while local");
    pin(IX_SEL, 1'b1);
    wr(OFS_CTRL, 32'h1);
  endtask : t_latch
  task automatic t_alarm;
    for (int k = 1; k <= 3; k++) begin
      pin(k, 1'b1);
      settle();
      check({alarm, gen_alarm}, {3'h1 << (k - 1), 1'b1}, "alarm raised");
      pin(IX_SEL, 1'b0);
      settle();
      check({alarm, gen_alarm}, 4'h0, "alarm while local");
      pin(IX_SEL, 1'b1);
      pin(k, 1'b0);
      settle();
      check({alarm, gen_alarm}, 4'h0, "alarm cleared");
    end
  endtask : t_alarm
  task automatic t_dir;
    pin(IX_DIR, 1'b1);
    settle();
    check({31'h0, dir_ccw}, 32'h1, "ccw when stopped");
    pin(IX_START, 1'b1);
    settle();
    pin(IX_DIR, 1'b0);
    settle();
    check({31'h0, dir_ccw}, 32'h1, "dir frozen running");
    pin(IX_START, 1'b0);
    settle();
    check({31'h0, dir_ccw}, 32'h0, "cw after stop");
  endtask : t_dir
  task automatic t_pulse;
    int n;
    int rpm[3] = '{400, 100, 0};
    pin(IX_START, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_SPEED, rpm[k]);
      settle();
      count_tgl(160, n);
      in_rng(n, rpm[k] / 10 - 1, rpm[k] / 10 + 1, "pulse toggles");
    end
    wr(OFS_SPEED, 32'h1FF);
    settle();
    check({23'h0, motor_rpm}, {23'h0, MAX_RPM}, "speed clamped");
    pin(IX_SEL, 1'b0);
    settle();
    count_tgl(80, n);
    check(n, 0, "pulse while local");
    pin(IX_SEL, 1'b1);
    pin(IX_START, 1'b0);
  endtask : t_pulse
  task automatic t_follow;
    logic [31:0] f;
    rpc_plant_model_inst.set_follow(3);
    wr(OFS_CTRL, 32'h3);
    pin(IX_START, 1'b1);
    repeat (700) @(posedge clk);
    xfer(1'b0, OFS_FREQ, 32'h0, f);
    in_rng(f, 33, 34, "follower count");
    in_rng(motor_rpm, 12, 13, "follower speed");
    wr(OFS_PCT, 32'h32);
    repeat (450) @(posedge clk);
    check({23'h0, motor_rpm}, 32'h6, "half of leader");
    rpc_plant_model_inst.set_follow(0);
    pin(IX_START, 1'b0);
  endtask : t_follow
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_maint();
    t_latch();
    t_alarm();
    t_dir();
    t_pulse();
    t_follow();
    stop_test();
  end
endmodule : tb_top
